// >>> hw/dbgsec_top.sv
// debug port gating, id security and break-related control
`timescale 1ns/1ps

// Notes on behaviour
// - debug valid only with mode bit and reset high
// - ten-byte stored id authenticates debugger
// - matching id releases security
// - last id byte bit 7 enables emulator
// - enable flag zero refuses debug anyway
// - erased id reads all ones
// - resets disarm flash software breakpoints
// - hardware or forced break rearms them
// - pin reset masked during break
// - pin reset still resets port buffers
// - debug data out driven high in debug
// - watchdog keeps counting in break case
// - interval timer keeps running in break case
// - debug reset low clears unit, rise resets cpu
// - sample on clock rise, drive on fall
// - mode writable only under debug reset
// - mode bit zero frees pins, drops pulldown
module dbgsec_top (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [dbgsec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [dbgsec_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         debug_reset_n,
  input  wire logic                         debug_clock_in,
  input  wire logic                         debug_transfer_select,
  input  wire logic                         debug_data_in,
  output logic                              debug_data_out,
  output logic                              debug_data_out_oe,
  output logic                              debug_reset_pulldown_en,
  output logic                              debug_pins_as_port,
  output logic                              debug_valid,
  output logic                              cpu_reset_req,
  input  wire logic                         system_reset_pin_n,
  input  wire logic                         secondary_watchdog_reset,
  input  wire logic                         break_active,
  input  wire logic                         hardware_break,
  input  wire logic                         forced_break,
  input  wire logic                         sw_break_hit,
  output logic                              sw_break_fire,
  output logic                              sw_break_armed,
  output logic                              cpu_periph_reset,
  output logic                              port_io_reset,
  output logic                              security_released,
  output logic                              flash_read_enable,
  output logic                              secondary_watchdog_run,
  output logic                              interval_timer_m_run
);
  import dbgsec_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pins_s;
  logic       debug_reset_n_s, dck_s, dms_s, ddi_s, rstpin_s;
  logic       dck_d, debug_reset_n_d;

  dbgsec_sync #(.W(5), .RESET_VAL(5'h10)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({system_reset_pin_n, debug_reset_n, debug_clock_in,
                debug_transfer_select, debug_data_in}),
    .sync_out (pins_s)
  );

  assign {rstpin_s, debug_reset_n_s, dck_s, dms_s, ddi_s} = pins_s;

  wire dck_rise  = dck_s & ~dck_d;
  wire dck_fall  = ~dck_s & dck_d;
  wire debug_reset_n_rise = debug_reset_n_s & ~debug_reset_n_d;
  wire pin_rst   = ~rstpin_s;

  // ****************************************
  // software registers
  // ****************************************
  logic                mode_select;
  logic [CONFIG_W-1:0] config_bits;
  dbgsec_byte_t        stored_id [ID_BYTES];
  logic                id_submitted;
  dbgsec_id_if         idl ();

  // id word as seen on the bus; bytes beyond the image read zero
  function automatic logic [31:0] id_word(input int word);
    logic [31:0] w;
    int          idx;
    w = '0;
    for (int lane = 0; lane < 4; lane++)
    begin
      idx = id_byte_index(word, lane);
      if (idx < ID_BYTES)
      begin
        w[8*lane +: 8] = stored_id[idx];
      end
    end
    return w;
  endfunction

  // ****************************************
  // axi4-lite decode
  // ****************************************
  wire wr_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire rd_go  = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire wa_mode  = s_axi_awaddr == OFS_MODE;
  wire wa_cfg   = s_axi_awaddr == OFS_CONFIG;
  wire wa_stat  = s_axi_awaddr == OFS_STATUS;
  wire wa_erase = s_axi_awaddr == OFS_ERASE;
  wire [1:0] wa_idw = (s_axi_awaddr == OFS_ID0) ? 2'h0 :
                      (s_axi_awaddr == OFS_ID1) ? 2'h1 :
                      (s_axi_awaddr == OFS_ID2) ? 2'h2 : 2'h3;
  wire wa_id    = wa_idw != 2'h3;
  wire wa_ok    = wa_mode | wa_cfg | wa_stat | wa_erase | wa_id;
  wire do_erase = wr_go & wa_erase & s_axi_wstrb[0] & s_axi_wdata[ERASE_BIT];

  wire [31:0] status_word = {25'h0, id_submitted, debug_reset_n_s, sw_break_armed,
                             security_released, idl.emu_enable, idl.match,
                             debug_valid};

  logic [31:0] rd_word;
  logic        rd_ok;

  always_comb
  begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFS_MODE:   rd_word = {31'h0, mode_select};
      OFS_CONFIG: rd_word = {27'h0, config_bits};
      OFS_STATUS: rd_word = status_word;
      OFS_ID0:    rd_word = id_word(0);
      OFS_ID1:    rd_word = id_word(1);
      OFS_ID2:    rd_word = id_word(2);
      OFS_ERASE:  rd_word = 32'h0000_0000;
      default:
      begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // only the pin reset (aresetn) restores the mode; watchdog and
  // clock-monitor resets never reach this flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_select <= MODE_RESET[MODE_SEL_BIT];
      config_bits <= CONFIG_RESET;
    end
    else if (wr_go & s_axi_wstrb[0])
    begin
      if (wa_mode & ~debug_reset_n_s)
      begin
        mode_select <= s_axi_wdata[MODE_SEL_BIT];
      end
      if (wa_cfg)
      begin
        config_bits <= s_axi_wdata[CONFIG_W-1:0];
      end
    end
  end

  // flash id image; erase brings every bit back to one
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < ID_BYTES; i++)
    begin
      if (!aresetn || do_erase)
      begin
        stored_id[i] <= ERASED_BYTE;
      end
      else if (wr_go && wa_id && i / 4 == int'(wa_idw) && s_axi_wstrb[i % 4])
      begin
        stored_id[i] <= s_axi_wdata[8*(i % 4) +: 8];
      end
    end
  end

  // ****************************************
  // id link over the debug serial pins
  // ****************************************
  dbgsec_idcheck u_idcheck (
    .aclk    (aclk),
    .aresetn (aresetn),
    .idp     (idl.cmp)
  );

  dbgsec_link_t       link_state;
  logic [6:0]         bit_cnt;
  logic [ID_BITS-1:0] presented;

  assign idl.stored    = stored_id;
  assign idl.presented = presented;

  // a debug-reset low or invalid port drops the frame and the release
  wire link_clear = ~debug_reset_n_s | ~debug_valid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || link_clear)
    begin
      link_state        <= LINK_IDLE;
      bit_cnt           <= 7'h00;
      presented         <= '0;
      id_submitted      <= 1'b0;
      security_released <= 1'b0;
    end
    else
    begin
      unique case (link_state)
        LINK_IDLE:
        begin
          if (dck_rise & dms_s)
          begin
            presented  <= {ddi_s, presented[ID_BITS-1:1]};
            bit_cnt    <= ID_CNT_W1;
            link_state <= LINK_SHIFT;
          end
        end
        LINK_SHIFT:
        begin
          if (dck_rise & dms_s & (bit_cnt != ID_CNT_FULL))
          begin
            presented <= {ddi_s, presented[ID_BITS-1:1]};
            bit_cnt   <= bit_cnt + 7'h01;
          end
          else if (dck_rise & ~dms_s)
          begin
            // a short frame is dropped without a verdict
            link_state <= (bit_cnt == ID_CNT_FULL) ? LINK_CHECK : LINK_IDLE;
          end
        end
        LINK_CHECK:
        begin
          id_submitted      <= 1'b1;
          security_released <= idl.match & idl.emu_enable;
          link_state        <= LINK_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin control and break handling
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dck_d                   <= 1'b0;
      debug_reset_n_d                  <= 1'b0;
      debug_valid             <= 1'b0;
      debug_data_out          <= 1'b0;
      debug_data_out_oe       <= 1'b0;
      debug_reset_pulldown_en <= 1'b1;
      debug_pins_as_port      <= 1'b1;
      cpu_reset_req           <= 1'b0;
      flash_read_enable       <= 1'b0;
    end
    else
    begin
      dck_d                   <= dck_s;
      debug_reset_n_d                  <= debug_reset_n_s;
      debug_valid             <= mode_select & debug_reset_n_s;
      debug_pins_as_port      <= ~(mode_select & debug_reset_n_s);
      debug_reset_pulldown_en <= mode_select;
      cpu_reset_req           <= debug_reset_n_rise;
      flash_read_enable       <= security_released;
      debug_data_out_oe       <= debug_valid;
      if (~debug_valid)
      begin
        debug_data_out <= 1'b0;
      end
      else if (dck_fall)
      begin
        debug_data_out <= 1'b1;
      end
    end
  end

  // a break that lands with a reset rearms: the break takes priority over the reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_break_armed         <= 1'b0;
      sw_break_fire          <= 1'b0;
      cpu_periph_reset       <= 1'b0;
      port_io_reset          <= 1'b0;
      secondary_watchdog_run <= 1'b1;
      interval_timer_m_run   <= 1'b1;
    end
    else
    begin
      if (hardware_break | forced_break)
      begin
        sw_break_armed <= 1'b1;
      end
      else if (pin_rst | secondary_watchdog_reset)
      begin
        sw_break_armed <= 1'b0;
      end
      sw_break_fire          <= sw_break_hit & sw_break_armed;
      cpu_periph_reset       <= (pin_rst & ~break_active) | debug_reset_n_rise;
      port_io_reset          <= pin_rst;
      secondary_watchdog_run <= ~break_active |
        (config_bits[CFG_WDT_MAIN_SUB] & config_bits[CFG_OSC_STOP]);
      interval_timer_m_run   <= ~break_active | ~config_bits[CFG_TMR_STOP_BRK] |
        (config_bits[CFG_TMR_SRC_SLOW] & config_bits[CFG_MAIN_STOP]);
    end
  end

endmodule // dbgsec_top

// >>> hw/dbgsec_pkg.sv
// constants and types shared by the debug gating and security block
package dbgsec_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFS_MODE   = 8'h00;
  localparam logic [7:0]  OFS_CONFIG = 8'h04;
  localparam logic [7:0]  OFS_STATUS = 8'h08;
  localparam logic [7:0]  OFS_ID0    = 8'h0C;
  localparam logic [7:0]  OFS_ID1    = 8'h10;
  localparam logic [7:0]  OFS_ID2    = 8'h14;
  localparam logic [7:0]  OFS_ERASE  = 8'h18;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // field layouts and reset values
  // ****************************************
  localparam logic [7:0]  MODE_RESET   = 8'h01;
  localparam int          MODE_SEL_BIT = 0;

  localparam int          CONFIG_W          = 5;
  localparam logic [4:0]  CONFIG_RESET      = 5'h00;
  localparam int          CFG_WDT_MAIN_SUB  = 0;
  localparam int          CFG_OSC_STOP      = 1;
  localparam int          CFG_TMR_STOP_BRK  = 2;
  localparam int          CFG_TMR_SRC_SLOW  = 3;
  localparam int          CFG_MAIN_STOP     = 4;

  localparam int          ST_VALID     = 0;
  localparam int          ST_MATCH     = 1;
  localparam int          ST_EMU_EN    = 2;
  localparam int          ST_RELEASED  = 3;
  localparam int          ST_SWBRK     = 4;
  localparam int          ST_DEBUG_RESET_N      = 5;
  localparam int          ST_SUBMITTED = 6;

  localparam int          ERASE_BIT = 0;

  // ****************************************
  // security id image
  // ****************************************
  localparam int          ID_BYTES       = 10;
  localparam int          ID_BITS        = 80;
  localparam logic [6:0]  ID_CNT_W1      = 7'h01;
  localparam logic [6:0]  ID_CNT_FULL    = 7'h50;
  localparam logic [31:0] ID_FLASH_FIRST = 32'h0000_0070;
  localparam logic [31:0] ID_FLASH_LAST  = 32'h0000_0079;
  localparam logic [31:0] SYS_RSVD_ADDR  = 32'h0000_007A;
  localparam logic [7:0]  SYS_RSVD_VALUE = 8'h00;
  localparam int          EMU_FLAG_BIT   = 7;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

  typedef logic [7:0] dbgsec_byte_t;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_CHECK = 2'b10
  } dbgsec_link_t;

  // byte of the id image behind lane of id word; ID_BYTES means none
  function automatic int id_byte_index(input int word, input int lane);
    int idx;
    idx = word * 4 + lane;
    return (idx < ID_BYTES) ? idx : ID_BYTES;
  endfunction

endpackage

// >>> hw/dbgsec_id_if.sv
// carrier between the security block and its id comparator
`timescale 1ns/1ps
interface dbgsec_id_if;
  import dbgsec_pkg::*;

  dbgsec_byte_t           stored [ID_BYTES];
  logic [ID_BITS-1:0]     presented;
  logic                   match;
  logic                   emu_enable;

  modport owner (output stored, output presented, input match, input emu_enable);
  modport cmp   (input stored, input presented, output match, output emu_enable);
endinterface

// >>> hw/dbgsec_sync.sv
// two-stage synchroniser for pins from outside the aclk domain
`timescale 1ns/1ps
module dbgsec_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // dbgsec_sync

// >>> hw/dbgsec_idcheck.sv
// compares the presented id with the stored flash id image
`timescale 1ns/1ps
module dbgsec_idcheck (
  input  wire logic aclk,
  input  wire logic aresetn,
  dbgsec_id_if.cmp  idp
);
  import dbgsec_pkg::*;

  logic next_match;

  always_comb
  begin
    next_match = 1'b1;
    for (int i = 0; i < ID_BYTES; i++)
    begin
      if (idp.stored[i] != idp.presented[8*i +: 8])
      begin
        next_match = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idp.match      <= 1'b0;
      idp.emu_enable <= 1'b1;
    end
    else
    begin
      idp.match      <= next_match;
      idp.emu_enable <= idp.stored[ID_BYTES-1][EMU_FLAG_BIT];
    end
  end
endmodule // dbgsec_idcheck

// >>> testbench/dbgsec_probe.sv
// behavioural debug probe driving the serial debug pins
`timescale 1ns/1ps
module dbgsec_probe (
  output logic debug_reset_n,
  output logic debug_clock_in,
  output logic debug_transfer_select,
  output logic debug_data_in
);
  // ****************************************
  // pin levels
  // ****************************************
  // reset pin held low until the bench has decided to use the debug port
  initial
  begin
    debug_reset_n         <= 1'h0;
    debug_clock_in        = 1'h0;
    debug_transfer_select = 1'h0;
    debug_data_in         = 1'h0;
  end

  task automatic set_reset(input logic v);
    debug_reset_n <= v;
  endtask

  // ****************************************
  // id frame, lsb first; clock stands low outside frames
  // ****************************************
  task automatic frame(input logic [79:0] id, input int n);
    for (int i = 0; i < n; i++)
    begin
      debug_transfer_select = 1'h1;
      debug_data_in         = id[i];
      #62.5 debug_clock_in  = 1'h1;
      #62.5 debug_clock_in  = 1'h0;
    end
    // closing rise with select low asks for the verdict
    debug_transfer_select = 1'h0;
    debug_data_in         = ~debug_data_in;
    #62.5 debug_clock_in  = 1'h1;
    #62.5 debug_clock_in  = 1'h0;
  endtask
endmodule // dbgsec_probe

// >>> testbench/dbgsec_top_asserts.sv
// concurrent checks on the ports of the debug gating and security block
`timescale 1ns/1ps
module dbgsec_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic debug_reset_n,
  input wire logic debug_valid,
  input wire logic debug_data_out,
  input wire logic debug_reset_pulldown_en,
  input wire logic debug_pins_as_port,
  input wire logic cpu_reset_req,
  input wire logic system_reset_pin_n,
  input wire logic secondary_watchdog_reset,
  input wire logic break_active,
  input wire logic hardware_break,
  input wire logic forced_break,
  input wire logic sw_break_hit,
  input wire logic sw_break_fire,
  input wire logic sw_break_armed,
  input wire logic cpu_periph_reset,
  input wire logic port_io_reset,
  input wire logic security_released,
  input wire logic secondary_watchdog_run,
  input wire logic interval_timer_m_run
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************
  // debug port gating
  // ****************************************
  // pin passes two sync flops and one output flop
  chk_valid_pin: assert property (debug_valid |-> $past(debug_reset_n, 3))
    else $error("debug valid without reset pin high");
  chk_pins_free: assert property (debug_valid |-> debug_reset_pulldown_en && !debug_pins_as_port)
    else $error("debug pins not owned in debug mode");
  chk_ddo_hold: assert property (debug_valid && debug_data_out |=> debug_data_out || !debug_valid)
    else $error("debug data out dropped in debug mode");
  chk_cpu_rst_rise: assert property (cpu_reset_req |-> $past(debug_reset_n, 3) && !$past(debug_reset_n, 4))
    else $error("cpu reset request without reset pin rise");

  // ****************************************
  // breakpoints and resets
  // ****************************************
  chk_fire_armed: assert property (sw_break_hit && sw_break_armed |=> sw_break_fire)
    else $error("armed software break did not fire");
  chk_fire_unarmed: assert property (sw_break_hit && !sw_break_armed |=> !sw_break_fire)
    else $error("disarmed software break fired");
  chk_rearm_break: assert property (hardware_break || forced_break |=> sw_break_armed)
    else $error("break did not rearm");
  chk_disarm_wdt: assert property (secondary_watchdog_reset && !hardware_break && !forced_break |=> !sw_break_armed)
    else $error("watchdog reset did not disarm");
  chk_rst_masked: assert property ($past(break_active) && !cpu_reset_req |-> !cpu_periph_reset)
    else $error("cpu reset during break");
  chk_port_rst: assert property (!system_reset_pin_n [*4] |-> port_io_reset)
    else $error("port reset missing");
  chk_wdt_run: assert property (!break_active |=> secondary_watchdog_run)
    else $error("watchdog stopped outside break");
  chk_tmr_run: assert property (!break_active |=> interval_timer_m_run)
    else $error("interval timer stopped outside break");

  cover property ($rose(security_released));
  cover property (sw_break_fire);
  cover property (cpu_reset_req);
endmodule // dbgsec_top_asserts

bind dbgsec_top dbgsec_top_asserts u_asserts (.*);

// >>> testbench/dbgsec_test.sv
// self-checking bench for the debug gating and security block
`timescale 1ns/1ps
module dbgsec_test;
  import dbgsec_pkg::*;
  localparam logic [79:0] ID = 80'hD423_F1DE_BC9A_7856_3412;
  logic              aclk, aresetn, system_reset_pin_n, secondary_watchdog_reset;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]        s_axi_awprot, s_axi_arprot;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              debug_reset_n, debug_clock_in, debug_transfer_select, debug_data_in;
  logic              debug_data_out, debug_data_out_oe, debug_reset_pulldown_en;
  logic              debug_pins_as_port, debug_valid, cpu_reset_req, break_active;
  logic              hardware_break, forced_break, sw_break_hit, sw_break_fire;
  logic              sw_break_armed, cpu_periph_reset, port_io_reset, security_released;
  logic              flash_read_enable, secondary_watchdog_run, interval_timer_m_run;
  logic [4:0]        cv;
  int                error_cnt = 0;
  int                samples_checked = 0;

  dbgsec_top dut (.*);
  dbgsec_probe probe (.debug_reset_n(debug_reset_n), .debug_clock_in(debug_clock_in),
    .debug_transfer_select(debug_transfer_select), .debug_data_in(debug_data_in));

  initial
  begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  // ****************************************
  // compare, bus and strobe tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // wait n edges, then look at settled outputs
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // m: hardware break, forced break, software hit, watchdog reset
  task automatic pl(input logic [3:0] m);
    @(posedge aclk);
    {hardware_break, forced_break, sw_break_hit, secondary_watchdog_reset} <= m;
    @(posedge aclk);
    {hardware_break, forced_break, sw_break_hit, secondary_watchdog_reset} <= 4'h0;
    @(negedge aclk);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // about 24 id frames of 2.5k cycles each, plus bus traffic
  initial
  begin
    #380_000;
    error_cnt++;
    $display("BAD %0t: timeout", $time);
    end_of_test;
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {hardware_break, forced_break, sw_break_hit, secondary_watchdog_reset} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hF;
    break_active = 1'h0;
    system_reset_pin_n = 1'h1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_MODE, 32'h1, RESP_OKAY);
    rd(OFS_ID0, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_ID2, 32'h0000_FFFF, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'h1, RESP_SLVERR);
    wt(1);
    chkb(debug_valid, 1'h0);
    $display("reset test done");
    wr(OFS_ID0, 32'h7856_3412, RESP_OKAY);
    wr(OFS_ID1, 32'hF1DE_BC9A, RESP_OKAY);
    wr(OFS_ID2, 32'h0000_D423, RESP_OKAY);
    probe.set_reset(1'h1);
    wt(8);
    chkb(debug_valid, 1'h1);
    chkb(debug_pins_as_port, 1'h0);
    wr(OFS_MODE, 32'h0, RESP_OKAY);
    rd(OFS_MODE, 32'h1, RESP_OKAY);
    probe.frame(ID, 80);
    wt(10);
    chkb(security_released, 1'h1);
    chkb(debug_data_out, 1'h1);
    chkb(debug_data_out_oe, 1'h1);
    rd(OFS_STATUS, 32'h6F, RESP_OKAY);
    // short frame gives no verdict
    probe.frame(ID, 79);
    wt(10);
    chkb(security_released, 1'h1);
    for (int k = 0; k < 10; k++)
    begin
      probe.frame(ID ^ (80'h1 << (8 * k + k % 8)), 80);
      wt(10);
      chkb(security_released, 1'h0);
      probe.frame(ID, 80);
      wt(10);
      chkb(flash_read_enable, 1'h1);
    end
    wr(OFS_ID2, 32'h0000_5423, RESP_OKAY);
    probe.frame({8'h54, ID[71:0]}, 80);
    wt(10);
    chkb(security_released, 1'h0);
    rd(OFS_STATUS, 32'h63, RESP_OKAY);
    wr(OFS_ERASE, 32'h1, RESP_OKAY);
    rd(OFS_ID1, 32'hFFFF_FFFF, RESP_OKAY);
    probe.frame({80{1'h1}}, 80);
    wt(10);
    chkb(security_released, 1'h1);
    $display("id test done");
    chkb(sw_break_armed, 1'h0);
    pl(4'h2);
    chkb(sw_break_fire, 1'h0);
    pl(4'h8);
    chkb(sw_break_armed, 1'h1);
    pl(4'h2);
    chkb(sw_break_fire, 1'h1);
    pl(4'h1);
    chkb(sw_break_armed, 1'h0);
    pl(4'h2);
    chkb(sw_break_fire, 1'h0);
    pl(4'h4);
    chkb(sw_break_armed, 1'h1);
    @(posedge aclk) break_active <= 1'h1;
    @(posedge aclk) system_reset_pin_n <= 1'h0;
    wt(6);
    chkb(cpu_periph_reset, 1'h0);
    chkb(port_io_reset, 1'h1);
    @(posedge aclk) break_active <= 1'h0;
    wt(3);
    chkb(cpu_periph_reset, 1'h1);
    @(posedge aclk) system_reset_pin_n <= 1'h1;
    $display("break test done");
    @(posedge aclk) break_active <= 1'h1;
    for (int c = 0; c < 32; c++)
    begin
      cv = c[4:0];
      wr(OFS_CONFIG, {27'h0, cv}, RESP_OKAY);
      wt(2);
      chkb(secondary_watchdog_run, cv[0] & cv[1]);
      chkb(interval_timer_m_run, !cv[2] | (cv[3] & cv[4]));
    end
    @(posedge aclk) break_active <= 1'h0;
    probe.set_reset(1'h0);
    wt(6);
    wr(OFS_MODE, 32'h0, RESP_OKAY);
    rd(OFS_MODE, 32'h0, RESP_OKAY);
    chkb(debug_reset_pulldown_en, 1'h0);
    probe.set_reset(1'h1);
    wt(6);
    chkb(debug_valid, 1'h0);
    chkb(debug_pins_as_port, 1'h1);
    chkb(debug_data_out_oe, 1'h0);
    $display("mode test done");
    end_of_test;
  end
endmodule // dbgsec_test
